// file: rtk_pkg.sv
// Purpose: Constants and types for the timekeeping supervisor core.
// Assumes: Register bus is a simple byte port driven by the serial front end.
// Notes: Time figures are named, cycle counts derived from the 125 MHz clock.
package rtk_pkg;
    // ==================================================
    // Register map
    localparam logic [7:0] ADDR_HUNDREDTHS = 8'h00;
    localparam logic [7:0] ADDR_SECONDS = 8'h01;
    localparam logic [7:0] ADDR_MINUTES = 8'h02;
    localparam logic [7:0] ADDR_HOURS = 8'h03;
    localparam logic [7:0] ADDR_DOW = 8'h04;
    localparam logic [7:0] ADDR_DOM = 8'h05;
    localparam logic [7:0] ADDR_MONTH = 8'h06;
    localparam logic [7:0] ADDR_YEAR = 8'h07;
    localparam logic [7:0] ADDR_CONTROL = 8'h08;
    localparam logic [7:0] ADDR_HALT_REG = 8'h0c;
    localparam logic [7:0] ADDR_FLAGS = 8'h0f;
    localparam logic [7:0] ADDR_LAST_CLOCK = 8'h07;

    // ==================================================
    // Field positions
    localparam int OSC_HALT_POS = 7;
    localparam int CENT_EN_POS = 7;
    localparam int CENT_BIT_POS = 6;
    localparam int FREEZE_POS = 6;
    localparam int BATT_LOW_POS = 4;
    localparam logic [7:0] DOW_MASK = 8'h07;
    localparam logic [7:0] CONTROL_RESET = 8'h00;

    // ==================================================
    // Timing
    localparam longint CLK_HZ = 125_000_000;
    localparam longint HUNDREDTH_NS = 10_000_000;
    localparam longint HUNDREDTH_CYCLES = HUNDREDTH_NS * CLK_HZ / 1_000_000_000;
    localparam longint BATT_CHECK_HOURS = 24;
    localparam longint BATT_CHECK_TICKS = BATT_CHECK_HOURS * 3600 * 100;
    localparam longint RECOVERY_MS = 200;
    localparam longint RECOVERY_CYCLES = RECOVERY_MS * CLK_HZ / 1000;

    typedef enum logic [1:0] {
        PWR_FAIL = 2'b00,
        PWR_RECOVER = 2'b01,
        PWR_GOOD = 2'b10
    } rtk_pwr_e;

    typedef struct packed {
        logic [7:0] hund;
        logic [7:0] sec;
        logic [7:0] min;
        logic [7:0] hour;
        logic [7:0] dow;
        logic [7:0] dom;
        logic [7:0] mon;
        logic [7:0] year;
    } rtk_time_s;

    typedef struct packed {
        logic rd;
        logic wr;
        logic stop;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rtk_bus_s;
endpackage : rtk_pkg

// file: rtk_core.sv
// Purpose: BCD timekeeping, update freeze, battery check and power-fail supervisor.
// Assumes: Serial front end hands over byte accesses and stop conditions on i_clk.
// Notes: Tick enable replaces the crystal; supply comparators arrive asynchronously.
// Function
// - Battery check at every power-up and every 24 hours while powered; the daily count runs on ticks, so it stops while the oscillator is halted.
// - Failed battery check sets battery_low_flag, bit 4 of flags 0Fh.
// - battery_low_flag clears only when a later check passes.
// - No battery checks while running from backup battery.
// - Eight BCD clock registers used both to set and read time.
// - Register 3 upper bits hold century enable and century toggle bit.
// - Century bit toggles at century turnover only when enabled.
// - Day of week sits in low three bits of register 4.
// - Registers 5, 6, 7 hold day of month, month, year.
// - Control register 08h accessed alone without clock registers.
// - Oscillator halt bit set stops timekeeping.
// - Clearing halt bit restarts timekeeping within one second.
// - Reading clock addresses suspends user copy update.
// - Power-up after failure sets freeze bit, holding the time at the end of recovery.
// - Host clears freeze bit; device then refreshes user copy.
// - Power-fail deselects device and write-protects clock registers.
// - Reset output asserted on power failure until supply nominal.
// - SRAM enable forced high while supply out of tolerance.
// - On battery supply SRAM enable and reset outputs go high impedance.
// - After supply returns, hold reset and SRAM inhibit for recovery time.
// - Read freeze releases on stop or pointer moving to RAM.
`timescale 1ns/1ps
module rtk_core #(
    parameter longint RECOVERY_CYCLES_P = rtk_pkg::RECOVERY_CYCLES,
    parameter longint BATT_TICKS_P = rtk_pkg::BATT_CHECK_TICKS,
    parameter longint TICK_CYCLES_P = rtk_pkg::HUNDREDTH_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire rtk_pkg::rtk_bus_s i_bus,
    input wire logic i_power_fail,
    input wire logic i_on_battery,
    input wire logic i_battery_low,
    input wire logic i_sram_enable_n,
    output logic [7:0] o_rdata,
    output logic o_sram_enable_out,
    output logic o_sram_enable_oe,
    output logic o_reset_output_n,
    output logic o_reset_output_oe,
    output logic o_deselected
);
    // ==================================================
    // Supply input synchronisers
    logic [2:0] sync1_q;
    logic [2:0] sync2_q;
    logic pfail;
    logic onbat;
    logic batlow;
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            sync1_q <= 3'h0;
            sync2_q <= 3'h0;
        end else begin
            sync1_q <= {i_battery_low, i_on_battery, i_power_fail};
            sync2_q <= sync1_q;
        end
    end
    assign pfail = sync2_q[0];
    assign onbat = sync2_q[1];
    assign batlow = sync2_q[2];

    // ==================================================
    // Power supervisor
    rtk_pkg::rtk_pwr_e pwr_q;
    logic [31:0] rec_cnt_q;
    logic powerup_pulse;
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            pwr_q <= rtk_pkg::PWR_FAIL;
            rec_cnt_q <= 32'h0;
        end else begin
            unique case (pwr_q)
                rtk_pkg::PWR_FAIL: begin
                    rec_cnt_q <= 32'h0;
                    if (!pfail) begin
                        pwr_q <= rtk_pkg::PWR_RECOVER;
                    end
                end
                rtk_pkg::PWR_RECOVER: begin
                    if (pfail) begin
                        pwr_q <= rtk_pkg::PWR_FAIL;
                    end else if (rec_cnt_q == 32'(RECOVERY_CYCLES_P - 1)) begin
                        pwr_q <= rtk_pkg::PWR_GOOD;
                    end else begin
                        rec_cnt_q <= rec_cnt_q + 32'h1;
                    end
                end
                rtk_pkg::PWR_GOOD: begin
                    if (pfail) begin
                        pwr_q <= rtk_pkg::PWR_FAIL;
                    end
                end
                default: pwr_q <= rtk_pkg::PWR_FAIL;
            endcase
        end
    end
    wire good = (pwr_q == rtk_pkg::PWR_GOOD);
    assign powerup_pulse = (pwr_q == rtk_pkg::PWR_RECOVER) && !pfail
        && (rec_cnt_q == 32'(RECOVERY_CYCLES_P - 1));
    assign o_deselected = !good;
    // reset held low; SRAM forced high
    assign o_reset_output_n = good;
    assign o_sram_enable_out = good ? i_sram_enable_n : 1'b1;
    assign o_sram_enable_oe = !onbat;
    assign o_reset_output_oe = !onbat;

    // ==================================================
    // Tick divider and internal timekeeping
    logic [31:0] div_q;
    logic tick;
    logic osc_halt_q;
    // halt stops divider; resumes at once on clear
    always_ff @(posedge i_clk) begin
        if (i_reset || osc_halt_q || div_q == 32'(TICK_CYCLES_P - 1)) begin
            div_q <= 32'h0;
        end else begin
            div_q <= div_q + 32'h1;
        end
    end
    assign tick = !osc_halt_q && (div_q == 32'(TICK_CYCLES_P - 1));

    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
    endfunction : bcd_inc

    function automatic logic [7:0] days_in(input logic [7:0] m, input logic [7:0] y);
        logic [7:0] yb;
        yb = y[7:4] * 8'h0a + {4'h0, y[3:0]};
        if (m == 8'h02) begin
            days_in = (yb[1:0] == 2'b00) ? 8'h29 : 8'h28;
        end else if (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h11) begin
            days_in = 8'h30;
        end else begin
            days_in = 8'h31;
        end
    endfunction : days_in

    rtk_pkg::rtk_time_s int_q;
    rtk_pkg::rtk_time_s usr_q;
    logic cent_en_q;
    logic cent_bit_q;
    logic wr_ok;
    logic clk_wr;
    assign wr_ok = good && i_bus.wr;
    // clock writes blocked unless supply good
    assign clk_wr = wr_ok && (i_bus.addr <= rtk_pkg::ADDR_LAST_CLOCK);

    // internal BCD counters, set through the same registers
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            int_q <= '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};
            cent_bit_q <= 1'b0;
        end else if (clk_wr) begin
            unique case (i_bus.addr)
                rtk_pkg::ADDR_HUNDREDTHS: int_q.hund <= i_bus.wdata;
                rtk_pkg::ADDR_SECONDS: int_q.sec <= {1'b0, i_bus.wdata[6:0]};
                rtk_pkg::ADDR_MINUTES: int_q.min <= {1'b0, i_bus.wdata[6:0]};
                rtk_pkg::ADDR_HOURS: begin
                    int_q.hour <= {2'b00, i_bus.wdata[5:0]};
                    cent_bit_q <= i_bus.wdata[rtk_pkg::CENT_BIT_POS];
                end
                // day of week low three bits
                rtk_pkg::ADDR_DOW: int_q.dow <= i_bus.wdata & rtk_pkg::DOW_MASK;
                rtk_pkg::ADDR_DOM: int_q.dom <= {2'b00, i_bus.wdata[5:0]};
                rtk_pkg::ADDR_MONTH: int_q.mon <= {3'b000, i_bus.wdata[4:0]};
                rtk_pkg::ADDR_YEAR: int_q.year <= i_bus.wdata;
                default: int_q.hund <= int_q.hund;
            endcase
        end else if (tick) begin
            int_q.hund <= bcd_inc(int_q.hund);
            if (int_q.hund == 8'h99) begin
                int_q.hund <= 8'h00;
                int_q.sec <= bcd_inc(int_q.sec);
                if (int_q.sec == 8'h59) begin
                    int_q.sec <= 8'h00;
                    int_q.min <= bcd_inc(int_q.min);
                    if (int_q.min == 8'h59) begin
                        int_q.min <= 8'h00;
                        int_q.hour <= bcd_inc(int_q.hour);
                        if (int_q.hour == 8'h23) begin
                            int_q.hour <= 8'h00;
                            int_q.dow <= (int_q.dow == 8'h07) ? 8'h01 : int_q.dow + 8'h01;
                            int_q.dom <= bcd_inc(int_q.dom);
                            if (int_q.dom == days_in(int_q.mon, int_q.year)) begin
                                int_q.dom <= 8'h01;
                                int_q.mon <= bcd_inc(int_q.mon);
                                if (int_q.mon == 8'h12) begin
                                    int_q.mon <= 8'h01;
                                    int_q.year <= bcd_inc(int_q.year);
                                    if (int_q.year == 8'h99) begin
                                        int_q.year <= 8'h00;
                                        if (cent_en_q) begin
                                            cent_bit_q <= !cent_bit_q;
                                        end
                                    end
                                end
                            end
                        end
                    end
                end
            end
        end
    end

    // ==================================================
    // Control bits
    logic [7:0] control_q;
    logic freeze_q;
    logic was_failed_q;
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            control_q <= rtk_pkg::CONTROL_RESET;
            osc_halt_q <= 1'b0;
            cent_en_q <= 1'b0;
        end else begin
            if (wr_ok && i_bus.addr == rtk_pkg::ADDR_CONTROL) begin
                control_q <= i_bus.wdata;
            end
            if (wr_ok && i_bus.addr == rtk_pkg::ADDR_SECONDS) begin
                osc_halt_q <= i_bus.wdata[rtk_pkg::OSC_HALT_POS];
            end
            if (wr_ok && i_bus.addr == rtk_pkg::ADDR_HOURS) begin
                cent_en_q <= i_bus.wdata[rtk_pkg::CENT_EN_POS];
            end
        end
    end

    // freeze set on power-up after failure; host clear
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            freeze_q <= 1'b0;
            was_failed_q <= 1'b0;
        end else begin
            if (pwr_q == rtk_pkg::PWR_FAIL) begin
                was_failed_q <= 1'b1;
            end else if (powerup_pulse) begin
                was_failed_q <= 1'b0;
            end
            if (powerup_pulse && was_failed_q) begin
                freeze_q <= 1'b1;
            end else if (wr_ok && i_bus.addr == rtk_pkg::ADDR_HALT_REG) begin
                freeze_q <= i_bus.wdata[rtk_pkg::FREEZE_POS];
            end
        end
    end

    // ==================================================
    // User copy and read freeze
    logic rd_hold_q;
    // hold on clock read; release on stop or RAM address
    // A read beside a stop wins, so a fresh hold is never lost
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            rd_hold_q <= 1'b0;
        end else if (i_bus.rd) begin
            rd_hold_q <= (i_bus.addr <= rtk_pkg::ADDR_LAST_CLOCK);
        end else if (i_bus.stop) begin
            rd_hold_q <= 1'b0;
        end
    end
    wire hold = rd_hold_q || freeze_q || (i_bus.rd && i_bus.addr <= rtk_pkg::ADDR_LAST_CLOCK);
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            usr_q <= '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};
        end else if (!hold) begin
            usr_q <= int_q;
        end
    end

    // ==================================================
    // Battery check
    logic [31:0] day_cnt_q;
    logic batt_low_q;
    logic check;
    // daily interval from ticks; only with supply good
    always_ff @(posedge i_clk) begin
        if (i_reset || !good || check) begin
            day_cnt_q <= 32'h0;
        end else if (tick) begin
            day_cnt_q <= day_cnt_q + 32'h1;
        end
    end
    assign check = powerup_pulse || (good && tick && day_cnt_q == 32'(BATT_TICKS_P - 1));
    // set on failure; clear on passing check
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            batt_low_q <= 1'b0;
        end else if (check) begin
            batt_low_q <= batlow;
        end
    end

    // ==================================================
    // Read data
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_rdata <= 8'h00;
        end else if (i_bus.rd) begin
            unique case (i_bus.addr)
                rtk_pkg::ADDR_HUNDREDTHS: o_rdata <= usr_q.hund;
                rtk_pkg::ADDR_SECONDS: o_rdata <= {osc_halt_q, usr_q.sec[6:0]};
                rtk_pkg::ADDR_MINUTES: o_rdata <= usr_q.min;
                rtk_pkg::ADDR_HOURS: o_rdata <= {cent_en_q, cent_bit_q, usr_q.hour[5:0]};
                rtk_pkg::ADDR_DOW: o_rdata <= usr_q.dow;
                rtk_pkg::ADDR_DOM: o_rdata <= usr_q.dom;
                rtk_pkg::ADDR_MONTH: o_rdata <= usr_q.mon;
                rtk_pkg::ADDR_YEAR: o_rdata <= usr_q.year;
                rtk_pkg::ADDR_CONTROL: o_rdata <= control_q;
                rtk_pkg::ADDR_HALT_REG: o_rdata <= {1'b0, freeze_q, 6'h00};
                rtk_pkg::ADDR_FLAGS: o_rdata <= {3'b000, batt_low_q, 4'h0};
                default: o_rdata <= 8'h00;
            endcase
        end
    end

    // ==================================================
    // Checks
    // Supply back, then steady for eight cycles
    sequence s_supply_back;
        pwr_q == rtk_pkg::PWR_FAIL && !pfail;
    endsequence
    sequence s_supply_steady;
        !pfail [*8];
    endsequence

    a_fail_resets: assert property (@(posedge i_clk) disable iff (i_reset)
        pfail |=> !o_reset_output_n && o_sram_enable_out) else $error("reset not held");
    // Only meaningful while the recovery count is at least eight cycles
    a_recover_hold: assert property (@(posedge i_clk) disable iff (i_reset)
        s_supply_back ##1 s_supply_steady |-> !o_reset_output_n && o_sram_enable_out)
        else $error("released before recovery");
    a_batt_flag_set: assert property (@(posedge i_clk) disable iff (i_reset)
        check |=> batt_low_q == $past(batlow)) else $error("battery flag wrong");
    a_no_check_fail: assert property (@(posedge i_clk) disable iff (i_reset)
        !good && !powerup_pulse |=> $stable(batt_low_q)) else $error("check on battery");
    a_halt_stops: assert property (@(posedge i_clk) disable iff (i_reset)
        osc_halt_q && !clk_wr |=> $stable(int_q)) else $error("time moved while halted");
    a_cent_hold: assert property (@(posedge i_clk) disable iff (i_reset)
        !cent_en_q && !(wr_ok && i_bus.addr == rtk_pkg::ADDR_HOURS) |=> $stable(cent_bit_q))
        else $error("century bit moved while disabled");
    a_read_hold: assert property (@(posedge i_clk) disable iff (i_reset)
        i_bus.rd && i_bus.addr <= rtk_pkg::ADDR_LAST_CLOCK |=> $stable(usr_q))
        else $error("user copy moved in read");
    a_user_refresh: assert property (@(posedge i_clk) disable iff (i_reset)
        !hold |=> usr_q == $past(int_q)) else $error("user copy not refreshed");
    a_freeze_pwrup: assert property (@(posedge i_clk) disable iff (i_reset)
        powerup_pulse && was_failed_q |=> freeze_q) else $error("freeze not set");
    a_freeze_holds: assert property (@(posedge i_clk) disable iff (i_reset)
        freeze_q |=> $stable(usr_q)) else $error("user copy moved while frozen");
    a_protect_wr: assert property (@(posedge i_clk) disable iff (i_reset)
        !good && !tick |=> $stable(int_q) && $stable(control_q))
        else $error("write while deselected");
    a_float_batt: assert property (@(posedge i_clk) disable iff (i_reset)
        onbat |-> !o_sram_enable_oe && !o_reset_output_oe) else $error("drive on battery");
    a_stop_release: assert property (@(posedge i_clk) disable iff (i_reset)
        i_bus.stop && !i_bus.rd |=> !rd_hold_q) else $error("hold not released");
    a_ram_release: assert property (@(posedge i_clk) disable iff (i_reset)
        i_bus.rd && i_bus.addr > rtk_pkg::ADDR_LAST_CLOCK |=> !rd_hold_q)
        else $error("hold kept past clock addresses");
endmodule : rtk_core

// file: rtk_host_model.sv
// Purpose: Host side model issuing byte accesses and stop pulses.
// Assumes: Strobes last one cycle and change at the falling edge.
// Notes: Read data is taken at the second falling edge after the answering edge.
`timescale 1ns/1ps
module rtk_host_model (
    input wire logic i_clk,
    input wire logic [7:0] i_rdata,
    output rtk_pkg::rtk_bus_s o_bus
);
    initial begin
        o_bus = '0;
    end

    // ==================================================
    // Bus cycles
    // Released address lines are inverted, write data inverted after a write and set to ff after a read, so stale values never pass
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clk);
        o_bus = '{rd: 1'b0, wr: 1'b1, stop: 1'b0, addr: a, wdata: d};
        @(negedge i_clk);
        o_bus = '{rd: 1'b0, wr: 1'b0, stop: 1'b0, addr: ~a, wdata: ~d};
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge i_clk);
        o_bus = '{rd: 1'b1, wr: 1'b0, stop: 1'b0, addr: a, wdata: 8'h00};
        @(negedge i_clk);
        o_bus = '{rd: 1'b0, wr: 1'b0, stop: 1'b0, addr: ~a, wdata: 8'hff};
        @(negedge i_clk);
        d = i_rdata;
    endtask : rd

    task automatic stop();
        @(negedge i_clk);
        o_bus.stop = 1'b1;
        @(negedge i_clk);
        o_bus.stop = 1'b0;
    endtask : stop
endmodule : rtk_host_model

// file: tb_rtc_timekeeping_supervisor.sv
// Purpose: Self-checking bench for the timekeeping supervisor core.
// Assumes: Shortened recovery, tick and battery interval parameters.
// Notes: Random fields come from an xorshift generator with a fixed seed.
`timescale 1ns/1ps
module tb_rtc_timekeeping_supervisor;
    localparam int REC = 10;
    logic i_clk;
    logic i_reset;
    rtk_pkg::rtk_bus_s bus;
    logic i_power_fail;
    logic i_on_battery;
    logic i_battery_low;
    logic i_sram_enable_n;
    logic [7:0] o_rdata;
    logic o_sram_enable_out;
    logic o_sram_enable_oe;
    logic o_reset_output_n;
    logic o_reset_output_oe;
    logic o_deselected;
    int n_mismatch = 0;
    int n_tests = 0;
    int k;
    logic [31:0] seed = 32'h6c60;
    logic [7:0] r;
    logic [7:0] a;
    logic [7:0] t [8];

    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end

    rtk_core #(.RECOVERY_CYCLES_P(REC), .BATT_TICKS_P(5), .TICK_CYCLES_P(4)) u_rtk_core (
        .i_clk(i_clk), .i_reset(i_reset), .i_bus(bus), .i_power_fail(i_power_fail),
        .i_on_battery(i_on_battery), .i_battery_low(i_battery_low),
        .i_sram_enable_n(i_sram_enable_n), .o_rdata(o_rdata),
        .o_sram_enable_out(o_sram_enable_out), .o_sram_enable_oe(o_sram_enable_oe),
        .o_reset_output_n(o_reset_output_n), .o_reset_output_oe(o_reset_output_oe),
        .o_deselected(o_deselected));

    rtk_host_model u_rtk_host_model (.i_clk(i_clk), .i_rdata(o_rdata), .o_bus(bus));

    // ==================================================
    // Helpers
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction : xs

    // Random BCD value in lo..hi
    function automatic logic [7:0] rnd(input int lo, input int hi);
        int n;
        seed = xs(seed);
        n = lo + int'(seed % (hi - lo + 1));
        return {4'(n / 10), 4'(n % 10)};
    endfunction : rnd

    task automatic results();
        $display("tests=%0d mismatches=%0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : results

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic rdc(input logic [7:0] adr, input logic [7:0] m, input logic [7:0] exp);
        logic [7:0] d;
        u_rtk_host_model.rd(adr, d);
        chk(d & m, exp);
    endtask : rdc

    task automatic wr(input logic [7:0] adr, input logic [7:0] d);
        u_rtk_host_model.wr(adr, d);
    endtask : wr

    task automatic cyc(input int n);
        repeat (n) @(negedge i_clk);
    endtask : cyc

    // SRAM enable must stay inhibited for the whole hold
    task automatic wait_good(output int c);
        c = 0;
        while (o_reset_output_n !== 1'b1 && c < 200) begin
            chk({7'h0, o_sram_enable_out}, 8'h01);
            cyc(1);
            c++;
        end
        if (c >= 200) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, o_reset_output_n, 1'b1);
            results();
        end
    endtask : wait_good

    // ==================================================
    // Main sequence
    initial begin
        i_reset = 1'b1;
        i_power_fail = 1'b0;
        i_on_battery = 1'b0;
        i_battery_low = 1'b1;
        i_sram_enable_n = 1'b0;
        cyc(10);
        chk({5'h0, o_reset_output_n, o_sram_enable_out, o_deselected}, 8'h03);
        i_reset = 1'b0;
        wait_good(k);
        chk({7'h0, k >= REC}, 8'h01);
        chk({7'h0, o_sram_enable_out}, 8'h00);
        $display("power-up done");

        rdc(rtk_pkg::ADDR_HALT_REG, 8'h40, 8'h40);
        rdc(rtk_pkg::ADDR_FLAGS, 8'h10, 8'h10);
        wr(rtk_pkg::ADDR_HALT_REG, 8'h00);
        rdc(rtk_pkg::ADDR_HALT_REG, 8'h40, 8'h00);
        i_battery_low = 1'b0;
        cyc(40);
        rdc(rtk_pkg::ADDR_FLAGS, 8'h10, 8'h00);
        i_battery_low = 1'b1;
        cyc(40);
        rdc(rtk_pkg::ADDR_FLAGS, 8'h10, 8'h10);
        wr(rtk_pkg::ADDR_FLAGS, 8'h00);
        rdc(rtk_pkg::ADDR_FLAGS, 8'h10, 8'h10);
        $display("battery check done");

        seed = xs(seed);
        r = seed[7:0];
        wr(rtk_pkg::ADDR_CONTROL, r);
        rdc(rtk_pkg::ADDR_CONTROL, 8'hff, r);
        i_sram_enable_n = r[0];
        cyc(1);
        chk({7'h0, o_sram_enable_out}, {7'h0, r[0]});
        rdc(8'h3f, 8'hff, 8'h00);
        $display("control done");

        // Halt set first so the readback cannot move
        for (int i = 0; i < 3; i++) begin
            t[1] = rnd(0, 59) | 8'h80;
            t[2] = rnd(0, 59);
            t[3] = rnd(0, 23) | {seed[1:0], 6'h00};
            t[4] = rnd(1, 7);
            t[5] = rnd(1, 28);
            t[6] = rnd(1, 12);
            t[7] = rnd(0, 99);
            for (int j = 1; j < 8; j++) wr(8'(j), t[j]);
            u_rtk_host_model.stop();
            cyc(4);
            for (int j = 1; j < 8; j++) rdc(8'(j), 8'hff, t[j]);
            u_rtk_host_model.stop();
        end
        $display("set and read done");

        wr(rtk_pkg::ADDR_SECONDS, 8'h00);
        u_rtk_host_model.stop();
        cyc(8);
        u_rtk_host_model.rd(rtk_pkg::ADDR_HUNDREDTHS, a);
        cyc(20);
        rdc(rtk_pkg::ADDR_HUNDREDTHS, 8'hff, a);
        u_rtk_host_model.stop();
        cyc(20);
        u_rtk_host_model.rd(rtk_pkg::ADDR_HUNDREDTHS, r);
        chk({7'h0, r !== a}, 8'h01);
        $display("read freeze done");

        // Last tick of a century, with and without rollover enable
        for (int c = 0; c < 2; c++) begin
            seed = xs(seed);
            t[3] = {c[0], seed[0], 6'h23};
            wr(8'h01, 8'hd9);
            wr(8'h00, 8'h99);
            wr(8'h02, 8'h59);
            wr(8'h03, t[3]);
            wr(8'h04, 8'h01);
            wr(8'h05, 8'h31);
            wr(8'h06, 8'h12);
            wr(8'h07, 8'h99);
            wr(8'h01, 8'h59);
            u_rtk_host_model.stop();
            cyc(12);
            rdc(8'h03, 8'hff, {c[0], seed[0] ^ c[0], 6'h00});
            rdc(8'h04, rtk_pkg::DOW_MASK, 8'h02);
            rdc(8'h05, 8'hff, 8'h01);
            rdc(8'h06, 8'hff, 8'h01);
            rdc(8'h07, 8'hff, 8'h00);
            u_rtk_host_model.stop();
        end
        $display("century done");

        r = 8'h3c;
        i_sram_enable_n = 1'b0;
        wr(rtk_pkg::ADDR_CONTROL, r);
        i_power_fail = 1'b1;
        cyc(4);
        chk({5'h0, o_reset_output_n, o_sram_enable_out, o_deselected}, 8'h03);
        wr(rtk_pkg::ADDR_CONTROL, 8'hc3);
        i_on_battery = 1'b1;
        cyc(4);
        chk({6'h0, o_sram_enable_oe, o_reset_output_oe}, 8'h00);
        i_on_battery = 1'b0;
        i_power_fail = 1'b0;
        wait_good(k);
        chk({7'h0, k >= REC}, 8'h01);
        chk({7'h0, o_sram_enable_out}, 8'h00);
        chk({6'h0, o_sram_enable_oe, o_reset_output_oe}, 8'h03);
        rdc(rtk_pkg::ADDR_CONTROL, 8'hff, r);
        rdc(rtk_pkg::ADDR_HALT_REG, 8'h40, 8'h40);
        $display("power fail done");
        results();
    end
endmodule : tb_rtc_timekeeping_supervisor
